// file: rtl/bc_regs_cfg.svh
`ifndef BC_REGS_CFG_SVH
`define BC_REGS_CFG_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define REG_CMD 6'h03
`define REG_TT 6'h05
`define REG_CAUSE 6'h06
`define REG_IRQ_EN 6'h10
`define REG_IRQ_CFG 6'h11

// ----------------------------------------
// Command bit positions
// ----------------------------------------
`define CMD_CORE_RST 0
`define CMD_START 1
`define CMD_IRQ_CLR 2
`define CMD_TT_CLR 3
`define CMD_STOP_EOF 5
`define CMD_STOP_EOM 6
`define CMD_PROTO_TEST 7
`define CMD_RAM_TEST 9
`define CMD_ST_CLR 10

// ----------------------------------------
// Cause bit positions
// ----------------------------------------
`define CS_ANY 15
`define CS_FAILSAFE 13
`define CS_STACK_WRAP 12
`define CS_PROTECT 9
`define CS_RETRY 8
`define CS_TT_WRAP 6
`define CS_MSG_SENT 4
`define CS_EOF 3
`define CS_RESP_ERR 2
`define CS_STATUS_ERR 1
`define CS_EOM 0
`define CS_USED 16'h335f

// ----------------------------------------
// Reset values and steps
// ----------------------------------------
`define RST_WORD 16'h0000
`define SP_STEP 16'h0004
`define IRQ_CFG_LEVEL 0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS 50
`define TT_TICK_NS 64000
`define TT_TICK_CYC (`TT_TICK_NS / `CLK_NS)
`define IRQ_PULSE_NS 500
`define IRQ_PULSE_CYC (`IRQ_PULSE_NS / `CLK_NS)

`endif

// file: rtl/bc_regs_pkg.sv
package bc_regs_pkg;
    typedef logic [15:0] word_t;
    typedef logic [5:0] reg_idx_t;
    typedef enum logic [1:0] {
        IRQ_IDLE,
        IRQ_PULSE,
        IRQ_LEVEL
    } irq_state_t;
endpackage

// file: rtl/tt_link_if.sv
`timescale 1ns/1ps
interface tt_link_if;
    logic load;
    logic clear;
    bc_regs_pkg::word_t load_val;
    bc_regs_pkg::word_t value;
    logic wrap;
    modport counter (
        input load,
        input clear,
        input load_val,
        output value,
        output wrap
    );
    modport user (
        output load,
        output clear,
        output load_val,
        input value,
        input wrap
    );
endinterface // tt_link_if

// file: rtl/time_tag_counter.sv
`timescale 1ns/1ps
`include "bc_regs_cfg.svh"
module time_tag_counter (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Link to register bank
    tt_link_if.counter tt
);
    import bc_regs_pkg::*;

    localparam logic [10:0] TICK_LAST = 11'(`TT_TICK_CYC - 1);

    logic [10:0] prescale;
    word_t count;
    logic wrap_q;
    wire tick = (prescale == TICK_LAST);
    wire [15:0] next_count = count + 16'h0001;

    always_ff @(posedge clk_i) begin
        if (rst_i || tt.clear) begin
            prescale <= 11'h000;
            count <= `RST_WORD;
            wrap_q <= 1'b0;
        end else if (ce_i) begin
            prescale <= tick ? 11'h000 : prescale + 11'h001;
            wrap_q <= tick && !tt.load && (count == 16'hffff);
            if (tt.load) begin
                count <= tt.load_val;
            end else if (tick) begin
                count <= next_count;
            end
        end
    end

    assign tt.value = count;
    assign tt.wrap = wrap_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    tt_load_a: assert property (tt.load && !tt.clear |=> count == $past(tt.load_val))
        else $error("time tag did not take written value");
    tt_wrap_a: assert property (tick && !tt.load && count == 16'hffff |=> count == 16'h0000 && tt.wrap)
        else $error("time tag wrap not seen");
    tt_tick_cov: cover property (tick ##1 prescale == 11'h000);
endmodule // time_tag_counter

// file: rtl/bus_ctrl_command_status_regs.sv
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "bc_regs_cfg.svh"
module bus_ctrl_command_status_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Command strobes to the controller
    output logic start_o,
    output logic stop_eom_o,
    output logic stop_eof_o,
    output logic ram_test_o,
    output logic proto_test_o,
    output logic selftest_clear_o,
    output logic core_reset_o,
    // Stack pointer
    input wire logic sp_load_i,
    input wire bc_regs_pkg::word_t sp_load_val_i,
    input wire logic message_done_flag_i,
    output bc_regs_pkg::word_t stack_ptr_o,
    // Message engine events
    input wire logic cmd_tx_i,
    input wire logic sync_tt_sel_i,
    input wire bc_regs_pkg::word_t mem_word_i,
    input wire logic msg_start_i,
    input wire logic msg_end_i,
    input wire logic msg_sent_i,
    input wire logic ctl_sent_irq_i,
    input wire logic frame_end_i,
    input wire logic failsafe_i,
    input wire logic stack_wrap_i,
    input wire logic retry_i,
    input wire logic no_resp_i,
    input wire logic bad_resp_i,
    input wire logic loopback_err_i,
    input wire logic wrong_addr_i,
    input wire logic status_bits_i,
    input wire logic status_valid_i,
    input wire logic broadcast_received_status_i,
    input wire logic ctl_broadcast_received_status_i,
    input wire logic broadcast_received_status_mask_mode_i,
    // Memory write guard
    input wire logic mem_wr_req_i,
    input wire logic protect_hit_i,
    output logic mem_wr_en_o,
    // Stamps to the stack and transmitter
    output bc_regs_pkg::word_t stamp_o,
    output bc_regs_pkg::word_t sync_word_o,
    output logic retry_seen_o,
    // Interrupt
    output logic irq_out_low_o
);
    import bc_regs_pkg::*;

    localparam logic [3:0] PULSE_LAST = 4'(`IRQ_PULSE_CYC - 1);

    function automatic logic reg_hit(input reg_idx_t idx, input reg_idx_t want);
        reg_hit = (idx == want);
    endfunction

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire reg_idx_t idx = adr_i[7:2];
    wire req = cyc_i && stb_i && !ack_o;
    wire wr_fire = req && we_i;
    wire rd_fire = req && !we_i;
    wire [15:0] lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [15:0] wdata = dat_i[15:0] & lane_mask;
    wire hit_cmd = reg_hit(idx, `REG_CMD);
    wire hit_tt = reg_hit(idx, `REG_TT);
    wire hit_cause = reg_hit(idx, `REG_CAUSE);
    wire hit_en = reg_hit(idx, `REG_IRQ_EN);
    wire hit_cfg = reg_hit(idx, `REG_IRQ_CFG);
    wire [15:0] cmd_fire = (wr_fire && hit_cmd) ? wdata : 16'h0000;
    wire cause_read = rd_fire && hit_cause;
    wire soft_rst = cmd_fire[`CMD_CORE_RST];
    logic core_rst_q;
    wire rst_all = rst_i || core_rst_q;

    // ----------------------------------------
    // State
    // ----------------------------------------
    word_t cmd_q;
    word_t sp;
    word_t cause;
    word_t irq_en;
    logic level_mode;
    irq_state_t irq_state;
    logic [3:0] pulse_cnt;

    tt_link_if tt ();

    time_tag_counter u_tt (
        .clk_i(clk_i),
        .rst_i(rst_all),
        .ce_i(ce_i),
        .tt(tt.counter)
    );

    assign tt.clear = cmd_fire[`CMD_TT_CLR];
    assign tt.load = wr_fire && hit_tt && !cmd_fire[`CMD_TT_CLR];
    assign tt.load_val = (dat_i[15:0] & lane_mask) | (tt.value & ~lane_mask);

    // ----------------------------------------
    // Cause flags
    // ----------------------------------------
    wire broadcast_received_status_miss = status_valid_i && !broadcast_received_status_mask_mode_i
        && (broadcast_received_status_i != ctl_broadcast_received_status_i);
    word_t set_vec;
    always_comb begin
        set_vec = 16'h0000;
        set_vec[`CS_FAILSAFE] = failsafe_i;
        set_vec[`CS_STACK_WRAP] = stack_wrap_i;
        set_vec[`CS_PROTECT] = protect_hit_i;
        set_vec[`CS_RETRY] = retry_i;
        set_vec[`CS_TT_WRAP] = tt.wrap;
        set_vec[`CS_MSG_SENT] = msg_sent_i && ctl_sent_irq_i;
        set_vec[`CS_EOF] = frame_end_i;
        set_vec[`CS_EOM] = msg_end_i;
        set_vec[`CS_RESP_ERR] = no_resp_i || bad_resp_i || loopback_err_i;
        set_vec[`CS_STATUS_ERR] = wrong_addr_i || status_bits_i || broadcast_received_status_miss;
    end

    wire cause_clr = cause_read || cmd_fire[`CMD_IRQ_CLR];
    wire [15:0] kept = cause_clr ? 16'h0000 : cause;
    wire [15:0] next_cause = (kept | set_vec) & `CS_USED;
    wire [15:0] cause_view = {|cause, cause[14:0]};
    wire new_irq = |(set_vec & irq_en & `CS_USED);

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire [15:0] rd_word = hit_cmd ? sp
        : hit_tt ? tt.value
        : hit_cause ? cause_view
        : hit_en ? irq_en
        : hit_cfg ? {15'h0000, level_mode}
        : 16'h0000;

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            core_rst_q <= 1'b0;
        end else if (ce_i) begin
            ack_o <= req;
            dat_o <= rd_fire ? {16'h0000, rd_word} : dat_o;
            core_rst_q <= soft_rst;
        end
    end

    // ----------------------------------------
    // Command strobes
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            cmd_q <= 16'h0000;
        end else if (ce_i) begin
            cmd_q <= cmd_fire;
        end
    end

    assign selftest_clear_o = cmd_q[`CMD_ST_CLR];
    assign ram_test_o = cmd_q[`CMD_RAM_TEST];
    assign proto_test_o = cmd_q[`CMD_PROTO_TEST];
    assign stop_eom_o = cmd_q[`CMD_STOP_EOM];
    assign stop_eof_o = cmd_q[`CMD_STOP_EOF];
    assign start_o = cmd_q[`CMD_START];
    assign core_reset_o = core_rst_q;

    // ----------------------------------------
    // Stack pointer
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            sp <= `RST_WORD;
        end else if (ce_i) begin
            if (sp_load_i) begin
                sp <= sp_load_val_i;
            end else if (message_done_flag_i) begin
                sp <= sp + `SP_STEP;
            end
        end
    end
    assign stack_ptr_o = sp;

    // ----------------------------------------
    // Cause and interrupt control registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            cause <= `RST_WORD;
            irq_en <= `RST_WORD;
            level_mode <= 1'b0;
        end else if (ce_i) begin
            cause <= next_cause;
            if (wr_fire && hit_en) begin
                irq_en <= (dat_i[15:0] & lane_mask & `CS_USED) | (irq_en & ~lane_mask);
            end
            if (wr_fire && hit_cfg && sel_i[0]) begin
                level_mode <= dat_i[`IRQ_CFG_LEVEL];
            end
        end
    end

    // ----------------------------------------
    // Stamps and retry note
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            stamp_o <= `RST_WORD;
            sync_word_o <= `RST_WORD;
            retry_seen_o <= 1'b0;
        end else if (ce_i) begin
            if (cmd_tx_i) begin
                stamp_o <= tt.value;
                sync_word_o <= sync_tt_sel_i ? tt.value : mem_word_i;
            end
            retry_seen_o <= retry_i || (retry_seen_o && !msg_start_i);
        end
    end

    assign mem_wr_en_o = mem_wr_req_i && !protect_hit_i;

    // ----------------------------------------
    // Interrupt output
    // ----------------------------------------
    irq_state_t next_irq_state;
    always_comb begin
        next_irq_state = irq_state;
        case (irq_state)
            IRQ_IDLE: begin
                if (new_irq) begin
                    next_irq_state = level_mode ? IRQ_LEVEL : IRQ_PULSE;
                end
            end
            IRQ_PULSE: begin
                if (pulse_cnt == PULSE_LAST) begin
                    next_irq_state = IRQ_IDLE;
                end
            end
            IRQ_LEVEL: begin
                if (cause_clr && !new_irq) begin
                    next_irq_state = IRQ_IDLE;
                end
            end
            default: begin
                next_irq_state = IRQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            irq_state <= IRQ_IDLE;
            pulse_cnt <= 4'h0;
        end else if (ce_i) begin
            irq_state <= next_irq_state;
            pulse_cnt <= (irq_state == IRQ_PULSE) ? pulse_cnt + 4'h1 : 4'h0;
        end
    end
    assign irq_out_low_o = (irq_state == IRQ_IDLE);

    // ----------------------------------------
    // Check helper: length of a low phase
    // ----------------------------------------
    logic [4:0] low_run;
    always_ff @(posedge clk_i) begin
        if (rst_all || irq_out_low_o) begin
            low_run <= 5'h00;
        end else if (ce_i && low_run != 5'h1f) begin
            low_run <= low_run + 5'h01;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    ack_single_a: assert property (ack_o |=> !ack_o)
        else $error("ack held more than one cycle");
    st_clear_a: assert property (wr_fire && hit_cmd && wdata[`CMD_ST_CLR] |=> selftest_clear_o)
        else $error("self test clear strobe missing");
    tests_a: assert property (wr_fire && hit_cmd
        |=> ram_test_o == $past(wdata[`CMD_RAM_TEST])
        && proto_test_o == $past(wdata[`CMD_PROTO_TEST]))
        else $error("self test strobe wrong");
    stop_strobe_a: assert property (stop_eom_o || stop_eof_o |=> !stop_eom_o && !stop_eof_o)
        else $error("stop strobe held");
    tt_clear_a: assert property (wr_fire && hit_cmd && wdata[`CMD_TT_CLR] |=> tt.value == 16'h0000)
        else $error("time tag not cleared");
    start_pulse_a: assert property (wr_fire && hit_cmd && wdata[`CMD_START] |=> start_o ##1 !start_o)
        else $error("start strobe not one cycle");
    core_rst_a: assert property (soft_rst |=> core_reset_o ##1 (cause == 16'h0000 && sp == 16'h0000))
        else $error("core reset incomplete");
    sp_read_a: assert property (rd_fire && hit_cmd |=> dat_o[15:0] == $past(sp))
        else $error("stack pointer readback wrong");
    sp_step_a: assert property (message_done_flag_i && !sp_load_i && !core_rst_q
        |=> sp == $past(sp) + 16'h0004)
        else $error("stack pointer step wrong");
    cause_clr_a: assert property (cause_clr && !core_rst_q
        |=> cause == $past(set_vec & `CS_USED))
        else $error("cause not cleared");
    cause_or_a: assert property (cause_view[15] == |cause[14:0] && (cause & ~`CS_USED) == 0)
        else $error("cause bit 15 or unused bits wrong");
    eom_set_a: assert property (msg_end_i && !core_rst_q |=> cause[`CS_EOM])
        else $error("end of message flag missing");
    guard_a: assert property (protect_hit_i |-> !mem_wr_en_o ##1 cause[`CS_PROTECT])
        else $error("protected write not blocked");
    irq_pulse_a: assert property ($rose(irq_out_low_o) && $past(irq_state) == IRQ_PULSE
        && !$past(core_reset_o) |-> low_run == 5'(`IRQ_PULSE_CYC))
        else $error("interrupt pulse length wrong");
    stamp_a: assert property (cmd_tx_i && !core_rst_q |=> stamp_o == $past(tt.value))
        else $error("time stamp not captured");
    irq_level_a: assert property (irq_state == IRQ_LEVEL && !cause_clr && !core_rst_q
        |=> !irq_out_low_o)
        else $error("level interrupt released early");
    wrap_flag_a: assert property (tt.wrap && !core_rst_q |=> cause[`CS_TT_WRAP])
        else $error("time tag wrap flag missing");
    ce_freeze_a: assert property (disable iff (rst_i) !ce_i && !core_rst_q
        |=> $stable(cause) && $stable(sp) && $stable(irq_state))
        else $error("state moved while clock enable low");

    pulse_cov: cover property (irq_state == IRQ_PULSE ##1 irq_state == IRQ_IDLE);
    level_cov: cover property (irq_state == IRQ_LEVEL ##[1:20] cause_read);
    start_cov: cover property (start_o);
    wrap_cov: cover property (cause[`CS_TT_WRAP]);
endmodule // bus_ctrl_command_status_regs

// file: testbench/wb_host_model.sv
`timescale 1ns/1ps
module wb_host_model (
    // Clock
    input wire logic clk_i,
    // Wishbone master
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    input wire logic [31:0] dat_i,
    input wire logic ack_i
);
    import bc_regs_pkg::*;

    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'hff;
        sel_o = 4'h0;
        dat_o = 32'hffffffff;
    end

    // Classic single cycle, held until ack is sampled high at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input word_t d,
                        output logic [31:0] r);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'h3;
        dat_o <= {16'h0000, d};
        @(posedge clk_i);
        while (ack_i !== 1'b1) begin
            @(posedge clk_i);
        end
        r = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        sel_o <= 4'h0;
        // Released lines show no stale value
        adr_o <= ~a;
        dat_o <= ~{16'h0000, d};
    endtask
endmodule // wb_host_model

// file: testbench/test_bus_ctrl_command_status_regs.sv
`timescale 1ns/1ps
module test_bus_ctrl_command_status_regs;
    import bc_regs_pkg::*;
    typedef struct packed {
        logic ev;
        logic [21:0] v;
        logic [15:0] e;
    } row_t;
    // ----------------------------------------
    // Rows: command word to strobes, event to cause word
    // ----------------------------------------
    localparam int NROW = 25;
    localparam row_t ROWS [NROW] = '{
        '{1'b0, 22'h2, 16'h1}, '{1'b0, 22'h40, 16'h4}, '{1'b0, 22'h20, 16'h2},
        '{1'b0, 22'h200, 16'h10}, '{1'b0, 22'h80, 16'h8}, '{1'b0, 22'h400, 16'h20},
        '{1'b0, 22'h0, 16'h0}, '{1'b0, 22'h8, 16'h0}, '{1'b0, 22'h4, 16'h0},
        '{1'b1, 22'h1, 16'h8001}, '{1'b1, 22'h6, 16'h8010}, '{1'b1, 22'h2, 16'h0},
        '{1'b1, 22'h8, 16'h8008}, '{1'b1, 22'h10, 16'ha000}, '{1'b1, 22'h20, 16'h9000},
        '{1'b1, 22'h40, 16'h8100}, '{1'b1, 22'h80, 16'h8004}, '{1'b1, 22'h100, 16'h8004},
        '{1'b1, 22'h200, 16'h8004}, '{1'b1, 22'h400, 16'h8002}, '{1'b1, 22'h800, 16'h8002},
        '{1'b1, 22'h3000, 16'h8002}, '{1'b1, 22'h7000, 16'h0}, '{1'b1, 22'hb000, 16'h0},
        '{1'b1, 22'h30000, 16'h8200}
    };
    logic clk_i;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    logic [21:0] ev = '0;
    logic sync_sel = 1'b0;
    word_t sp_val = 16'h0000;
    word_t mem_word = 16'h0000;
    logic cyc, stb, we, ack, core_rst, irq_out_low, mem_wr_en, retry_seen;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [5:0] strb;
    logic [5:0] strb_acc = '0;
    word_t stack_ptr, stamp, sync_word;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc_n = 0;
    int strb_cyc = 0;
    int irq_low_cyc = 0;
    int rst_seen = 0;

    bus_ctrl_command_status_regs u_bus_ctrl_command_status_regs (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack),
        .start_o(strb[0]), .stop_eof_o(strb[1]), .stop_eom_o(strb[2]),
        .proto_test_o(strb[3]), .ram_test_o(strb[4]), .selftest_clear_o(strb[5]),
        .core_reset_o(core_rst),
        .sp_load_i(ev[21]), .sp_load_val_i(sp_val), .message_done_flag_i(ev[20]),
        .stack_ptr_o(stack_ptr),
        .cmd_tx_i(ev[18]), .sync_tt_sel_i(sync_sel), .mem_word_i(mem_word),
        .msg_start_i(ev[19]), .msg_end_i(ev[0]), .msg_sent_i(ev[1]), .ctl_sent_irq_i(ev[2]),
        .frame_end_i(ev[3]), .failsafe_i(ev[4]), .stack_wrap_i(ev[5]), .retry_i(ev[6]),
        .no_resp_i(ev[7]), .bad_resp_i(ev[8]), .loopback_err_i(ev[9]),
        .wrong_addr_i(ev[10]), .status_bits_i(ev[11]), .status_valid_i(ev[12]),
        .broadcast_received_status_i(ev[13]), .ctl_broadcast_received_status_i(ev[14]),
        .broadcast_received_status_mask_mode_i(ev[15]),
        .mem_wr_req_i(ev[16]), .protect_hit_i(ev[17]), .mem_wr_en_o(mem_wr_en),
        .stamp_o(stamp), .sync_word_o(sync_word), .retry_seen_o(retry_seen),
        .irq_out_low_o(irq_out_low)
    );

    wb_host_model u_wb_host_model (
        .clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
        .dat_o(wdat), .dat_i(rdat), .ack_i(ack)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(negedge clk_i) begin
        strb_acc = strb_acc | strb;
        if (|strb) strb_cyc++;
        if (irq_out_low === 1'b0) irq_low_cyc++;
        if (core_rst === 1'b1) rst_seen++;
    end

    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 8000) begin
            bad_count++;
            results();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t word got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_b(input logic g, input logic e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t bit got %b exp %b", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input word_t d);
        logic [31:0] r;
        u_wb_host_model.xfer(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input word_t e);
        logic [31:0] r;
        u_wb_host_model.xfer(1'b0, a, 16'h0000, r);
        chk_w(r, {16'h0000, e});
    endtask

    task automatic pulse(input logic [21:0] v);
        @(posedge clk_i);
        ev <= v;
        @(posedge clk_i);
        ev <= '0;
        @(negedge clk_i);
    endtask

    task results;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk_b(irq_out_low, 1'b1);
        chk_w({16'h0, stack_ptr}, 32'h0);
        rd_chk(8'h14, 16'h0000);
        rd_chk(8'h18, 16'h0000);
        for (int i = 0; i < NROW; i++) begin
            if (!ROWS[i].ev) begin
                strb_acc = '0;
                strb_cyc = 0;
                wr(8'h0c, ROWS[i].v[15:0]);
                repeat (3) @(posedge clk_i);
                chk_w({26'h0, strb_acc}, {16'h0, ROWS[i].e});
                chk_w(32'(strb_cyc), (ROWS[i].e != 0) ? 32'h1 : 32'h0);
            end else begin
                pulse(ROWS[i].v);
                rd_chk(8'h18, ROWS[i].e);
                rd_chk(8'h18, 16'h0000);
            end
        end
        pulse(22'h40);
        chk_b(retry_seen, 1'b1);
        pulse(22'h80000);
        chk_b(retry_seen, 1'b0);
        rd_chk(8'h18, 16'h8100);
        @(posedge clk_i);
        ev <= 22'h10000;
        @(negedge clk_i);
        chk_b(mem_wr_en, 1'b1);
        @(posedge clk_i);
        ev <= 22'h30000;
        @(negedge clk_i);
        chk_b(mem_wr_en, 1'b0);
        @(posedge clk_i);
        ev <= '0;
        rd_chk(8'h18, 16'h8200);
        pulse(22'h8);
        wr(8'h0c, 16'h0004);
        rd_chk(8'h18, 16'h0000);
        @(posedge clk_i);
        ev <= 22'h10;
        wr(8'h0c, 16'h0004);
        ev <= '0;
        rd_chk(8'h18, 16'ha000);
        wr(8'h0c, 16'h0008);
        rd_chk(8'h14, 16'h0000);
        wr(8'h14, 16'h1234);
        rd_chk(8'h14, 16'h1234);
        repeat (1290) @(posedge clk_i);
        rd_chk(8'h14, 16'h1235);
        wr(8'h0c, 16'h0008);
        wr(8'h14, 16'hffff);
        repeat (1290) @(posedge clk_i);
        rd_chk(8'h14, 16'h0000);
        rd_chk(8'h18, 16'h8040);
        wr(8'h14, 16'h0777);
        sync_sel <= 1'b1;
        pulse(22'h40000);
        chk_w({16'h0, stamp}, 32'h0777);
        chk_w({16'h0, sync_word}, 32'h0777);
        sync_sel <= 1'b0;
        mem_word <= 16'hbeef;
        pulse(22'h40000);
        chk_w({16'h0, sync_word}, 32'hbeef);
        sp_val <= 16'hfffc;
        pulse(22'h200000);
        rd_chk(8'h0c, 16'hfffc);
        pulse(22'h100000);
        chk_w({16'h0, stack_ptr}, 32'h0);
        pulse(22'h100000);
        rd_chk(8'h0c, 16'h0004);
        wr(8'h40, 16'h0001);
        irq_low_cyc = 0;
        pulse(22'h1);
        repeat (25) @(posedge clk_i);
        chk_w(32'(irq_low_cyc), 32'd10);
        rd_chk(8'h18, 16'h8001);
        pulse(22'h8);
        repeat (5) @(posedge clk_i);
        chk_w(32'(irq_low_cyc), 32'd10);
        rd_chk(8'h18, 16'h8008);
        wr(8'h44, 16'h0001);
        pulse(22'h1);
        repeat (20) @(negedge clk_i);
        chk_b(irq_out_low, 1'b0);
        rd_chk(8'h18, 16'h8001);
        repeat (2) @(negedge clk_i);
        chk_b(irq_out_low, 1'b1);
        wr(8'h14, 16'h0555);
        pulse(22'h8);
        rst_seen = 0;
        wr(8'h0c, 16'h0001);
        repeat (3) @(posedge clk_i);
        chk_w(32'(rst_seen), 32'h1);
        chk_w({16'h0, stack_ptr}, 32'h0);
        rd_chk(8'h14, 16'h0000);
        rd_chk(8'h18, 16'h0000);
        // Event while clock enable is low is not latched
        @(posedge clk_i);
        ce <= 1'b0;
        pulse(22'h1);
        @(posedge clk_i);
        ce <= 1'b1;
        rd_chk(8'h18, 16'h0000);
        // Unmapped index reads zero and is still answered
        rd_chk(8'hfc, 16'h0000);
        results();
    end
endmodule // test_bus_ctrl_command_status_regs
